/* rtl/smsp_port.v */
// serial peripheral port, master or slave, with apb register access
`include "smsp_defs.vh"
module smsp_port (
  input  wire       clk_sys,
  input  wire       rst,
  input  wire [7:0] paddr,
  input  wire       psel,
  input  wire       penable,
  input  wire       pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire       pready,
  output wire       pslverr,
  input  wire       sckIn,
  output wire       sckOut,
  output wire       sckOe_n,
  input  wire       mosiIn,
  output wire       mosiOut,
  output wire       mosiOe_n,
  input  wire       misoIn,
  output wire       misoOut,
  output wire       misoOe_n,
  input  wire       ss_n,
  input  wire       ssIsInput,
  input  wire       irqAck,
  output wire       irqReq,
  output wire [1:0] irqLevel,
  output reg        dmaReq
);

////////////////////////////////////////////////////////////////////////////
// state
reg  [7:0] ctrl_r;
reg  [1:0] lvl_r;
reg        doneFlag_r;
reg        wcolFlag_r;
reg        doneSeen_r;
reg        wcolSeen_r;
reg  [7:0] tx_r;
reg  [7:0] rxSh_r;
reg  [7:0] rxBuf_r;
reg  [2:0] sampCnt_r;
reg  [3:0] edgeCnt_r;
reg  [5:0] divCnt_r;
reg        busy_r;
reg        sckLvl_r;
reg        outBit_r;
reg        sckS1_r;
reg        sckS2_r;
reg        sckS3_r;

wire en     = ctrl_r[`SMSP_CTL_ENABLE];
wire master = ctrl_r[`SMSP_CTL_MASTER];
wire lsbF   = ctrl_r[`SMSP_CTL_ORDER];
wire cpol   = ctrl_r[`SMSP_CTL_CPOL];
wire cpha   = ctrl_r[`SMSP_CTL_CPHA];

////////////////////////////////////////////////////////////////////////////
// apb decode
wire       mapped  = (paddr[7:4] == 4'h0) && (paddr[1:0] == 2'h0);
wire [1:0] idx     = paddr[3:2];
wire       access  = psel & penable;
wire       wrEv    = access & pwrite & mapped;
wire       rdEv    = access & ~pwrite & mapped;
wire       dataAcc = (wrEv | rdEv) && (idx == `SMSP_IDX_DATA);
wire       dataWr  = wrEv && (idx == `SMSP_IDX_DATA);
wire       flagRd  = rdEv && (idx == `SMSP_IDX_FLAGS);
wire       ctrlWr  = wrEv && (idx == `SMSP_IDX_CONTROL);
wire       lvlWr   = wrEv && (idx == `SMSP_IDX_SPI_INTERRUPT_CONTROL);

assign pready  = 1'b1;
assign pslverr = access & ~mapped;

////////////////////////////////////////////////////////////////////////////
// edge generation
reg  [5:0] half;
always @* begin
  case ({ctrl_r[`SMSP_CTL_DOUBLE], ctrl_r[`SMSP_CTL_DIV_HI:`SMSP_CTL_DIV_LO]})
    3'h0:    half = `SMSP_HALF_DIV4;
    3'h1:    half = `SMSP_HALF_DIV16;
    3'h2:    half = `SMSP_HALF_DIV64;
    3'h3:    half = `SMSP_HALF_DIV128;
    3'h4:    half = `SMSP_HALF_DIV2;
    3'h5:    half = `SMSP_HALF_DIV8;
    3'h6:    half = `SMSP_HALF_DIV32;
    default: half = `SMSP_HALF_DIV64;
  endcase
end

wire mActive = en & master & busy_r;
wire mTick   = mActive && (divCnt_r == half);
wire sActive = en & ~master & ~ss_n;
wire sRise   = sActive & sckS2_r & ~sckS3_r;
wire sFall   = sActive & ~sckS2_r & sckS3_r;

// polarity decides which sck edge leads a bit cell
reg  sLead;
reg  sTrail;
always @* begin
  if (cpol) begin
    sLead  = sFall;
    sTrail = sRise;
  end else begin
    sLead  = sRise;
    sTrail = sFall;
  end
end

wire leadEv  = (mTick & ~edgeCnt_r[0]) | sLead;
wire trailEv = (mTick & edgeCnt_r[0]) | sTrail;
wire sampEv  = cpha ? trailEv : leadEv;
wire setupEv = cpha ? leadEv : trailEv;
wire mDone   = mTick && (edgeCnt_r == `SMSP_LAST_EDGE);
wire sDone   = sampEv & ~master && (sampCnt_r == `SMSP_LAST_SAMPLE);
wire xferEnd = mDone | sDone;

// slave is busy once its first bit has been sampled
reg  busy;
always @* begin
  if (master) begin
    busy = busy_r;
  end else begin
    busy = (sampCnt_r != 3'h0);
  end
end

wire fault    = en & master & ssIsInput & ~ss_n;
wire idleHold = !en || fault || (!master && ss_n);

////////////////////////////////////////////////////////////////////////////
// shift data paths
wire       inBit   = master ? misoIn : mosiIn;
wire [7:0] txSh;
wire [7:0] rxSh;
wire       curBit  = lsbF ? tx_r[0] : tx_r[7];
wire       nextBit = lsbF ? txSh[0] : txSh[7];

// per-bit shift neighbours, direction set by bit order
genvar gi;
generate
  for (gi = 0; gi < 8; gi = gi + 1) begin : gBit
    if (gi == 0) begin : gLsb
      assign txSh[gi] = lsbF ? tx_r[gi + 1] : 1'b0;
      assign rxSh[gi] = lsbF ? rxSh_r[gi + 1] : inBit;
    end else if (gi == 7) begin : gMsb
      assign txSh[gi] = lsbF ? 1'b0 : tx_r[gi - 1];
      assign rxSh[gi] = lsbF ? inBit : rxSh_r[gi - 1];
    end else begin : gMid
      assign txSh[gi] = lsbF ? tx_r[gi + 1] : tx_r[gi - 1];
      assign rxSh[gi] = lsbF ? rxSh_r[gi + 1] : rxSh_r[gi - 1];
    end
  end
endgenerate

always @(posedge clk_sys) begin
  if (rst) begin
    sckS1_r <= 1'b0;
    sckS2_r <= 1'b0;
    sckS3_r <= 1'b0;
  end else begin
    sckS1_r <= sckIn;
    sckS2_r <= sckS1_r;
    sckS3_r <= sckS2_r;
  end
end

////////////////////////////////////////////////////////////////////////////
// dma request
always @(posedge clk_sys) begin
  if (rst) begin
    dmaReq <= 1'b0;
  end else begin
    dmaReq <= sDone;
  end
end

////////////////////////////////////////////////////////////////////////////
// master sck divider and level
always @(posedge clk_sys) begin
  if (rst) begin
    divCnt_r <= 6'h00;
  end else if (idleHold || !mActive) begin
    divCnt_r <= 6'h00;
  end else begin
    divCnt_r <= mTick ? 6'h00 : divCnt_r + 6'h01;
  end
end

always @(posedge clk_sys) begin
  if (rst) begin
    sckLvl_r <= 1'b0;
  end else if (idleHold || !busy_r) begin
    sckLvl_r <= cpol;
  end else if (mTick) begin
    sckLvl_r <= ~sckLvl_r;
  end
end

////////////////////////////////////////////////////////////////////////////
// shift engine
always @(posedge clk_sys) begin
  if (rst) begin
    tx_r      <= `SMSP_BYTE_ZERO;
    rxSh_r    <= `SMSP_BYTE_ZERO;
    rxBuf_r   <= `SMSP_BYTE_ZERO;
    sampCnt_r <= 3'h0;
    edgeCnt_r <= 4'h0;
    busy_r    <= 1'b0;
    outBit_r  <= 1'b0;
  end else if (idleHold) begin
    busy_r    <= 1'b0;
    sampCnt_r <= 3'h0;
    edgeCnt_r <= 4'h0;
    rxSh_r    <= `SMSP_BYTE_ZERO;
    if (dataWr && !master) begin
      tx_r <= pwdata[7:0];
    end
    if (!cpha) begin
      outBit_r <= curBit;
    end
  end else begin
    if (dataWr && !busy) begin
      tx_r <= pwdata[7:0];
      if (!cpha) begin
        outBit_r <= lsbF ? pwdata[0] : pwdata[7];
      end
      if (master) begin
        busy_r    <= 1'b1;
        edgeCnt_r <= 4'h0;
      end
    end else begin
      if (!busy && !cpha) begin
        outBit_r <= curBit;
      end
      if (setupEv) begin
        outBit_r <= cpha ? curBit : nextBit;
        tx_r     <= txSh;
      end
    end
    if (mTick) begin
      edgeCnt_r <= edgeCnt_r + 4'h1;
    end
    if (sampEv) begin
      rxSh_r    <= rxSh;
      sampCnt_r <= sampCnt_r + 3'h1;
    end
    if (mDone) begin
      busy_r <= 1'b0;
    end
    if (xferEnd) begin
      rxBuf_r <= sampEv ? rxSh : rxSh_r;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// registers and flags
always @(posedge clk_sys) begin
  if (rst) begin
    ctrl_r <= `SMSP_CTL_RESET;
  end else if (ctrlWr) begin
    ctrl_r <= pwdata[7:0];
  end else if (fault) begin
    ctrl_r[`SMSP_CTL_MASTER] <= 1'b0;
  end
end

always @(posedge clk_sys) begin
  if (rst) begin
    lvl_r <= `SMSP_LVL_RESET;
  end else if (lvlWr) begin
    lvl_r <= pwdata[1:0];
  end
end

////////////////////////////////////////////////////////////////////////////
// status flags and their read-then-access clear
always @(posedge clk_sys) begin
  if (rst) begin
    doneSeen_r <= 1'b0;
  end else if (flagRd && prdata[`SMSP_FLG_DONE]) begin
    doneSeen_r <= 1'b1;
  end else if (dataAcc) begin
    doneSeen_r <= 1'b0;
  end
end

always @(posedge clk_sys) begin
  if (rst) begin
    wcolSeen_r <= 1'b0;
  end else if (flagRd && prdata[`SMSP_FLG_WCOL]) begin
    wcolSeen_r <= 1'b1;
  end else if (dataAcc) begin
    wcolSeen_r <= 1'b0;
  end
end

always @(posedge clk_sys) begin
  if (rst) begin
    doneFlag_r <= 1'b0;
  end else if (xferEnd || fault) begin
    doneFlag_r <= 1'b1;
  end else if (irqAck || (dataAcc && doneSeen_r)) begin
    doneFlag_r <= 1'b0;
  end
end

always @(posedge clk_sys) begin
  if (rst) begin
    wcolFlag_r <= 1'b0;
  end else if (dataWr && en && busy) begin
    wcolFlag_r <= 1'b1;
  end else if (dataAcc && wcolSeen_r) begin
    wcolFlag_r <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////
// read data, loaded in the setup cycle
reg  [7:0] rdByte;
always @* begin
  rdByte = `SMSP_BYTE_ZERO;
  case (idx)
    `SMSP_IDX_CONTROL: rdByte = ctrl_r;
    `SMSP_IDX_SPI_INTERRUPT_CONTROL: rdByte = {6'h00, lvl_r};
    `SMSP_IDX_FLAGS:   rdByte = {doneFlag_r, wcolFlag_r, 6'h00};
    default:           rdByte = rxBuf_r;
  endcase
end

always @(posedge clk_sys) begin
  if (rst) begin
    prdata <= 32'h0000_0000;
  end else if (psel && !penable) begin
    if (mapped && !pwrite) begin
      prdata <= {24'h00_0000, rdByte};
    end else begin
      prdata <= 32'h0000_0000;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// pins and interrupt
assign sckOut   = sckLvl_r;
assign mosiOut  = outBit_r;
assign misoOut  = outBit_r;
assign sckOe_n  = ~(en & master);
assign mosiOe_n = ~(en & master);
assign misoOe_n = ~(en & ~master & ~ss_n);
assign irqLevel = lvl_r;
assign irqReq   = (lvl_r != `SMSP_LVL_RESET) & doneFlag_r;

endmodule // smsp_port

/* rtl/smsp_defs.vh */
// constants for the serial peripheral port: offsets, fields, timing
`ifndef SMSP_DEFS_VH
`define SMSP_DEFS_VH

// register indices; byte address is four times the index
`define SMSP_IDX_CONTROL     2'h0
`define SMSP_IDX_SPI_INTERRUPT_CONTROL     2'h1
`define SMSP_IDX_FLAGS       2'h2
`define SMSP_IDX_DATA        2'h3

// control fields
`define SMSP_CTL_DOUBLE      7
`define SMSP_CTL_ENABLE      6
`define SMSP_CTL_ORDER       5
`define SMSP_CTL_MASTER      4
`define SMSP_CTL_CPOL        3
`define SMSP_CTL_CPHA        2
`define SMSP_CTL_DIV_HI      1
`define SMSP_CTL_DIV_LO      0

// flag fields
`define SMSP_FLG_DONE        7
`define SMSP_FLG_WCOL        6

// reset values
`define SMSP_CTL_RESET       8'h00
`define SMSP_LVL_RESET       2'h0
`define SMSP_BYTE_ZERO       8'h00

// half periods of master sck in clk_sys cycles, minus one
`define SMSP_HALF_DIV4       6'h01
`define SMSP_HALF_DIV16      6'h07
`define SMSP_HALF_DIV64      6'h1f
`define SMSP_HALF_DIV128     6'h3f
`define SMSP_HALF_DIV2       6'h00
`define SMSP_HALF_DIV8       6'h03
`define SMSP_HALF_DIV32      6'h0f

// index of the last bit and last edge in a byte (8 bits, 16 edges)
`define SMSP_LAST_SAMPLE     3'h7
`define SMSP_LAST_EDGE       4'hf
`endif

/* verif/smsp_slave_model.sv */
// behavioural spi slave on the far side of the master port
module smsp_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] txByte,
  output logic            miso,
  output logic [7:0]      rxByte
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh;
  logic       bitR = 1'b0;
  // released line shows the inverse of the last bit
  assign miso = sel_n ? ~bitR : bitR;
  // select from outside logic, mode 0/2 present first bit
  always @(negedge sel_n) begin
    {bitR, sh} = mode[0] ? {1'b0, txByte} : {txByte, 1'b0};
  end
  always @(sck) begin
    if (!sel_n && (sck ^ mode[1] ^ mode[0]))  // sample edge
      rxByte = {rxByte[6:0], mosi};
    else if (!sel_n)                          // setup edge
      {bitR, sh} = {sh, 1'b0};
  end
endmodule // smsp_slave_model

/* verif/smsp_port_props.sv */
// assertion checker for the serial port, bound to its top
module smsp_port_chk (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        sckOe_n,
  input wire logic        mosiOe_n,
  input wire logic        misoOe_n,
  input wire logic        ss_n,
  input wire logic        ssIsInput,
  input wire logic        irqAck,
  input wire logic        irqReq,
  input wire logic [1:0]  irqLevel,
  input wire logic        dmaReq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  unmapped_err_a: assert property (psel && penable |->
    pslverr == (paddr[7:4] != 4'h0 || paddr[1:0] != 2'h0))
    else $error("pslverr wrong");
  flag_spare_a: assert property (
    psel && penable && !pwrite && paddr == 8'h08 |-> prdata[5:0] == 6'h00)
    else $error("spare flag bits set");
  irq_level_a: assert property (irqReq |-> irqLevel != 2'h0)
    else $error("irq with level zero");
  irq_ack_a: assert property (irqAck |=> !irqReq)
    else $error("irq kept after ack");
  dma_pulse_a: assert property (dmaReq |=> !dmaReq)
    else $error("dma request too long");
  dma_master_a: assert property (!sckOe_n [*2] |-> !dmaReq)
    else $error("dma request as master");
  master_pins_a: assert property (!sckOe_n |-> !mosiOe_n && misoOe_n)
    else $error("master pin drive wrong");
  fault_drop_a: assert property (
    !sckOe_n && ssIsInput && !ss_n |-> ##[1:4] sckOe_n)
    else $error("master kept on fault");
endmodule // smsp_port_chk
bind smsp_port smsp_port_chk chk (.*);

/* verif/test_smsp_port.sv */
// self-checking bench for the serial peripheral port
module test_smsp_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, ss_n = 1;
  logic ssIsInput = 0, irqAck = 0, selN = 1;
  logic bSck = 0, bMosi = 1, dmaSeen = 0;
  logic [7:0] paddr = 8'h00, txB = 8'h00;
  logic [31:0] pwdata = 32'h0, r;
  logic [1:0] md = 2'h0;
  wire [31:0] prdata;
  wire [7:0] rxB;
  wire [1:0] irqLevel;
  wire pready, pslverr, sckOut, sckOe_n, mosiOut, mosiOe_n, misoOut;
  wire misoOe_n, irqReq, dmaReq, sMiso;
  wire sckIn = sckOe_n ? bSck : sckOut;
  wire mosiIn = mosiOe_n ? bMosi : mosiOut;
  wire misoIn = misoOe_n ? sMiso : misoOut;
  int fail_count = 0, n_tests = 0, cyc = 0;
  int hp[4] = '{2, 8, 32, 64};
  smsp_port dut (.*);
  smsp_slave_model slv (.sck(sckIn), .mosi(mosiIn), .sel_n(selN),
    .mode(md), .txByte(txB), .miso(sMiso), .rxByte(rxB));
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (!rst) dmaSeen <= dmaSeen | dmaReq;
  always @(posedge clk_sys) if (++cyc == 40000) begin
    fail_count++;
    final_report();
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys) penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic edge_wait(output int n);
    logic s;
    s = sckOut;
    n = 0;
    while (sckOut === s && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    apb(0, 8'h00, 0);
    chk("ctrl reset", 0, r);
    apb(1, 8'h00, 8'h10);
    apb(1, 8'h0c, 8'ha5);
    repeat (20) @(posedge clk_sys);
    chk("sck off", 1, sckOe_n);
    apb(0, 8'h08, 0);
    chk("flags", 0, r);
    apb(0, 8'h10, 0);
    chk("unmapped", 0, r);
    $display("register test done");
  endtask
  task automatic t_xfer();
    logic [7:0] c, d, e, f;
    int n, k;
    for (int i = 0; i < 8; i++) begin
      c = {i[2], 1'b1, i[0], 1'b1, i[1:0], i[1:0]};
      md = i[1:0];
      txB = 8'hc5 ^ i[7:0];
      d = 8'h1e + i[7:0];
      e = {<<{d}};
      f = {<<{txB}};
      apb(1, 8'h04, {6'h0, i[1:0]});
      apb(1, 8'h00, c);
      @(negedge clk_sys) chk("sck idle", i[1], sckOut);
      @(posedge clk_sys);
      selN <= 0;
      apb(1, 8'h0c, d);
      apb(1, 8'h0c, 8'hff);
      edge_wait(n);
      edge_wait(n);
      @(posedge clk_sys);
      chk("half period", hp[i[1:0]] >> i[2], n);
      k = 0;
      do begin
        apb(0, 8'h08, 0);
        k++;
      end while (r[7] !== 1'b1 && k < 600);
      chk("flags", 8'hc0, r);
      chk("irq", i[1:0] != 0, irqReq);
      chk("slave rx", i[0] ? e : d, rxB);
      apb(0, 8'h0c, 0);
      chk("data", i[0] ? f : txB, r);
      apb(0, 8'h08, 0);
      chk("flags clear", 0, r);
      selN <= 1;
      @(posedge clk_sys);
    end
    $display("transfer test done");
  endtask
  task automatic t_fault();
    apb(1, 8'h00, 8'h50);
    ssIsInput <= 1;
    ss_n <= 0;
    repeat (4) @(posedge clk_sys);
    ss_n <= 1;
    ssIsInput <= 0;
    apb(0, 8'h00, 0);
    chk("master drop", 8'h40, r);
    chk("irq set", 1, irqReq);
    irqAck <= 1;
    @(posedge clk_sys) irqAck <= 0;
    @(posedge clk_sys);
    chk("irq ack", 0, irqReq);
    $display("mode fault test done");
  endtask
  task automatic t_slave();
    logic [7:0] m, v;
    v = 8'h96;
    chk("no dma as master", 0, dmaSeen);
    apb(1, 8'h00, 8'h43);
    apb(1, 8'h0c, 8'h3c);
    ss_n <= 0;
    for (int j = 7; j >= 0; j--) begin
      bMosi <= v[j];
      repeat (4) @(posedge clk_sys);
      m = {m[6:0], misoOut};
      bSck <= 1;
      repeat (4) @(posedge clk_sys);
      bSck <= 0;
      repeat (4) @(posedge clk_sys);
    end
    ss_n <= 1;
    chk("slave miso", 8'h3c, m);
    chk("dma pulse", 1, dmaSeen);
    apb(0, 8'h08, 0);
    chk("slave flags", 8'h80, r);
    apb(0, 8'h0c, 0);
    chk("slave rx", 8'h96, r);
    $display("slave test done");
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 0;
    @(posedge clk_sys);
    t_regs();
    t_xfer();
    t_fault();
    t_slave();
    final_report();
  end
endmodule // test_smsp_port
